// [apm_pkg.sv]
// Timing constants and states for the page-mode memory controller
package apm_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_PGSL_NS     = 10;
  localparam int unsigned T_PGSH_NS     = 10;
  localparam int unsigned T_EP_NS       = 45;
  localparam int unsigned T_AA_NS       = 45;
  localparam int unsigned T_AAP_NS      = 15;
  localparam int unsigned T_PWC_NS      = 15;
  localparam int unsigned T_EH_NS       = 10;
  localparam int unsigned T_WP_NS       = 25;
  // Least times round up, never below one cycle
  function automatic int unsigned cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned PGS_CYC  = cyc(T_PGSL_NS > T_PGSH_NS ?
                                         T_PGSL_NS : T_PGSH_NS);
  localparam int unsigned AA_CYC   = cyc(T_AA_NS > T_EP_NS ?
                                         T_AA_NS : T_EP_NS);
  localparam int unsigned AAP_CYC  = cyc(T_AAP_NS);
  localparam int unsigned WP_CYC   = cyc(T_WP_NS > T_PWC_NS ?
                                         T_WP_NS : T_PWC_NS);
  localparam int unsigned EH_CYC   = cyc(T_EH_NS);
  localparam int unsigned CNT_W    = 4;
  typedef enum logic [5:0] {
    APM_IDLE  = 6'h01,
    APM_MODE  = 6'h02,
    APM_RD    = 6'h04,
    APM_WR_LO = 6'h08,
    APM_WR_HI = 6'h10,
    APM_EHI   = 6'h20
  } apm_state_t;
endpackage

// [apm_ctrl.sv]
// Host controller for an asynchronous page-mode persistent memory
// Function
// - Page select low, chip select high, before access
// - Page select high settles before next select
// - Page read starts like single-word read
// - First page write pulse long enough
// - Further pulses, select low, write adjacent words
// - Hold select low until write completes
// - Select low at least minimum per access
// - Write strobe stays high during reads
// - Address valid before select falls
`timescale 1ns/1ps
`default_nettype none
module apm_ctrl #(
  parameter int unsigned AW = 26,
  parameter int unsigned DW = 32
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          req_valid,
  input  wire logic          req_write,
  input  wire logic          req_page,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  input  wire logic          req_last,
  output logic               req_ready,
  output logic               rsp_valid,
  output logic [DW-1:0]      rsp_rdata,
  output logic [AW-1:0]      mem_addr,
  output logic               bank_one_select_n,
  output logic               mem_oe_n,
  output logic               mem_we_n,
  output logic               page_mode_select_n,
  input  wire logic [DW-1:0] mem_dq_i,
  output logic [DW-1:0]      mem_dq_o,
  output logic               mem_dq_oe
);
  apm_pkg::apm_state_t state_r;
  logic [apm_pkg::CNT_W-1:0] cnt_r;
  logic [DW-1:0]             dq_s1_r;
  logic [DW-1:0]             dq_s2_r;
  logic [DW-1:0]             dq_s3_r;
  logic                      page_r;
  logic                      wr_r;
  logic                      last_r;
  logic                      open_r;
  logic [AW-3:0]             page_addr_r;

  function automatic logic [apm_pkg::CNT_W-1:0] cw(input int unsigned v);
    return v[apm_pkg::CNT_W-1:0];
  endfunction

  // Counter runs down on its own; states only load it
  wire cnt_done = (cnt_r == '0);
  // Page opened by a read is reused by reads of that page in page mode
  wire in_page  = open_r && page_r && !wr_r &&
                  (req_addr[AW-1:2] == page_addr_r);

  // Data pin input synchroniser; read only once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      dq_s3_r <= '0;
    end else begin
      dq_s1_r <= mem_dq_i;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
    end
  end

  // Pins and handshake; one access in flight, nothing queued
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r            <= apm_pkg::APM_IDLE;
      cnt_r              <= '0;
      req_ready          <= 1'b0;
      rsp_valid          <= 1'b0;
      rsp_rdata          <= '0;
      mem_addr           <= '0;
      bank_one_select_n  <= 1'b1;
      mem_oe_n           <= 1'b1;
      mem_we_n           <= 1'b1;
      page_mode_select_n <= 1'b1;
      mem_dq_o           <= '0;
      mem_dq_oe          <= 1'b0;
      page_r             <= 1'b0;
      wr_r               <= 1'b0;
      last_r             <= 1'b0;
      open_r             <= 1'b0;
      page_addr_r        <= '0;
    end else begin
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      if (!cnt_done) cnt_r <= cnt_r - cw(1);

      unique case (state_r)
        apm_pkg::APM_IDLE: begin
          if (req_valid && !req_ready) begin
            req_ready <= 1'b1;
            page_r    <= req_page;
            wr_r      <= req_write;
            last_r    <= req_last;
            mem_dq_o  <= req_wdata;
            // Address goes out here; chip select is still high unless a page is open
            mem_addr  <= req_addr;
            if (in_page && (req_page == page_r) && !req_write) begin
              cnt_r   <= cw(apm_pkg::AAP_CYC + 2);
              state_r <= apm_pkg::APM_RD;
            end else if (open_r) begin
              // Close the access before a mode or page change
              bank_one_select_n <= 1'b1;
              mem_oe_n          <= 1'b1;
              mem_dq_oe         <= 1'b0;
              open_r            <= 1'b0;
              cnt_r             <= cw(apm_pkg::EH_CYC);
              state_r           <= apm_pkg::APM_EHI;
            end else begin
              // Page select level alone sets mode, chip select high
              page_mode_select_n <= ~req_page;
              cnt_r              <= cw(apm_pkg::PGS_CYC);
              state_r            <= apm_pkg::APM_MODE;
            end
          end
        end
        apm_pkg::APM_EHI: begin
          // Chip select high time passes before the mode pin moves
          if (cnt_done) begin
            page_mode_select_n <= ~page_r;
            cnt_r              <= cw(apm_pkg::PGS_CYC);
            state_r            <= apm_pkg::APM_MODE;
          end
        end
        apm_pkg::APM_MODE: begin
          if (cnt_done) begin
            bank_one_select_n <= 1'b0;
            page_addr_r       <= mem_addr[AW-1:2];
            open_r            <= page_r;
            if (wr_r) begin
              // Data is driven from the strobe's falling edge on
              mem_we_n  <= 1'b0;
              mem_dq_oe <= 1'b1;
              cnt_r     <= cw(apm_pkg::WP_CYC);
              state_r   <= apm_pkg::APM_WR_LO;
            end else begin
              mem_we_n <= 1'b1;
              mem_oe_n <= 1'b0;
              // Extra cycles cover the three-stage data synchroniser
              cnt_r    <= cw(apm_pkg::AA_CYC + 2);
              state_r  <= apm_pkg::APM_RD;
            end
          end
        end
        apm_pkg::APM_RD: begin
          if (cnt_done && dq_s2_r == dq_s3_r) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= dq_s3_r;
            // Single word or last of page: end the access
            if (!page_r || last_r) begin
              bank_one_select_n <= 1'b1;
              mem_oe_n          <= 1'b1;
              open_r            <= 1'b0;
            end
            state_r <= apm_pkg::APM_IDLE;
          end
        end
        apm_pkg::APM_WR_LO: begin
          // Strobe rise commits the word, chip select still low
          if (cnt_done) begin
            mem_we_n <= 1'b1;
            cnt_r    <= cw(1);
            state_r  <= apm_pkg::APM_WR_HI;
          end
        end
        apm_pkg::APM_WR_HI: begin
          // Chip select only rises after the strobe has risen
          if (cnt_done) begin
            mem_dq_oe <= 1'b0;
            rsp_valid <= 1'b1;
            state_r   <= apm_pkg::APM_IDLE;
            // Page stays open for the next word unless marked last
            if (page_r && !last_r && !req_valid) begin
              open_r <= 1'b1;
            end else if (page_r && !last_r) begin
              open_r <= 1'b1;
            end else begin
              bank_one_select_n <= 1'b1;
              open_r            <= 1'b0;
            end
          end
        end
        default: state_r <= apm_pkg::APM_IDLE;
      endcase

      // Page write: next adjacent word without raising chip select
      if (state_r == apm_pkg::APM_IDLE && req_valid && !req_ready &&
          open_r && wr_r && page_r && req_write && req_page &&
          req_addr[AW-1:2] == page_addr_r) begin
        mem_addr  <= req_addr;
        mem_dq_o  <= req_wdata;
        mem_dq_oe <= 1'b1;
        mem_we_n  <= 1'b0;
        bank_one_select_n <= 1'b0;
        mem_oe_n  <= 1'b1;
        last_r    <= req_last;
        // Page stays open; overrides the close chosen in idle
        open_r    <= 1'b1;
        wr_r      <= 1'b1;
        cnt_r     <= cw(apm_pkg::WP_CYC);
        state_r   <= apm_pkg::APM_WR_LO;
      end
    end
  end
endmodule // apm_ctrl
`default_nettype wire

// [apm_ctrl_checker.sv]
// Pin assertions for the page-mode memory controller
`timescale 1ns/1ps
`default_nettype none
module apm_ctrl_checker #(parameter int unsigned AW = 26) (
  input wire logic          core_clk,
  input wire logic          rst,
  input wire logic          req_ready,
  input wire logic          rsp_valid,
  input wire logic [AW-1:0] mem_addr,
  input wire logic          bank_one_select_n,
  input wire logic          mem_oe_n,
  input wire logic          mem_we_n,
  input wire logic          page_mode_select_n,
  input wire logic          mem_dq_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_pg_set;
    $fell(bank_one_select_n) |-> $stable(page_mode_select_n);
  endproperty
  a_pg_set: assert property (p_pg_set) else $error("page select moved");
  property p_pg_hold;
    !bank_one_select_n |-> $stable(page_mode_select_n);
  endproperty
  a_pg_hold: assert property (p_pg_hold) else $error("mode moved");
  property p_adr; $fell(bank_one_select_n) |-> $stable(mem_addr); endproperty
  a_adr: assert property (p_adr) else $error("address late");
  property p_ep; $fell(bank_one_select_n) |=> !bank_one_select_n; endproperty
  a_ep: assert property (p_ep) else $error("select too short");
  property p_rd; !mem_oe_n |-> mem_we_n && !mem_dq_oe; endproperty
  a_rd: assert property (p_rd) else $error("strobe low in read");
  property p_wr;
    $fell(mem_we_n) |-> !bank_one_select_n ##1
                        (!mem_we_n && !bank_one_select_n);
  endproperty
  a_wr: assert property (p_wr) else $error("bad write pulse");
  property p_wend; $rose(mem_we_n) |-> !bank_one_select_n; endproperty
  a_wend: assert property (p_wend) else $error("select rose early");
  property p_wd; !mem_we_n |-> mem_dq_oe; endproperty
  a_wd: assert property (p_wd) else $error("write data not driven");
  property p_rsp; req_ready |-> ##[2:20] rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("no access done");
  c_pwr: cover property (!mem_we_n && !page_mode_select_n);
  c_prd: cover property (!mem_oe_n && !page_mode_select_n);
  c_srd: cover property (!mem_oe_n && page_mode_select_n);
endmodule // apm_ctrl_checker
`default_nettype wire

// [apm_mem_model.sv]
// Behavioural page-mode memory device on the far side
`timescale 1ns/1ps
`default_nettype none
module apm_mem_model (
  input  wire logic        sel_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        pg_n,
  input  wire logic [25:0] addr,
  input  wire logic [31:0] dq_i,
  output logic      [31:0] dq_q
);
  logic [31:0] mem [32];
  logic [31:0] pbuf [4];
  logic [31:0] last = 32'h0;
  always @(negedge sel_n or addr[25:2])
    if (!sel_n) for (int i = 0; i < 4; i++) pbuf[i] = mem[{addr[4:2], 2'(i)}];
  // Raised select before strobe end drops the word
  always @(posedge we_n) if (!sel_n) mem[addr[4:0]] <= dq_i;
  // Undriven bus shows inverted last value, never a stale copy
  always @* begin
    if (!sel_n && !oe_n && we_n) begin
      dq_q = pg_n ? mem[addr[4:0]] : pbuf[addr[1:0]];
      last = dq_q;
    end else dq_q = ~last;
  end
endmodule // apm_mem_model
`default_nettype wire

// [apm_ctrl_tb_top.sv]
// Self-checking bench for the page-mode memory controller
`timescale 1ns/1ps
`default_nettype none
module apm_ctrl_tb_top;
  logic core_clk, rst, req_valid, req_write, req_page, req_last;
  logic req_ready, rsp_valid, sel_n, oe_n, we_n, pg_n, dq_oe;
  logic [25:0] req_addr, mem_addr;
  logic [31:0] req_wdata, rsp_rdata, dq_o, dq_q, dq_bus, r;
  logic [31:0] sh [32];
  logic [32:0] exp_q [$];
  int fails = 0, total_checks = 0;
  assign dq_bus = dq_oe ? dq_o : dq_q;
  apm_ctrl dut (.core_clk, .rst, .req_valid, .req_write, .req_page,
    .req_addr, .req_wdata, .req_last, .req_ready, .rsp_valid, .rsp_rdata,
    .mem_addr, .bank_one_select_n(sel_n), .mem_oe_n(oe_n), .mem_we_n(we_n),
    .page_mode_select_n(pg_n), .mem_dq_i(dq_bus), .mem_dq_o(dq_o),
    .mem_dq_oe(dq_oe));
  apm_mem_model dev (.sel_n, .oe_n, .we_n, .pg_n, .addr(mem_addr),
    .dq_i(dq_bus), .dq_q);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, p, l, input logic [25:0] a);
    int n;
    @(negedge core_clk);
    r = lfsr(r);
    {req_valid, req_write, req_page, req_last, req_addr} = {1'b1, w, p, l, a};
    req_wdata = r;
    exp_q.push_back({~w, sh[a[4:0]]});
    if (w) sh[a[4:0]] = r;
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin @(negedge core_clk); n++; end
    req_valid = 0;
    while (rsp_valid !== 1'b1 && n < 40) begin @(negedge core_clk); n++; end
    chk("handshake", 32'h1, 32'(n < 40));
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(negedge core_clk)
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected result", 32'h0, 32'h1);
      else if (exp_q[0][32]) chk("read data", exp_q[0][31:0], rsp_rdata);
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    {rst, req_valid, req_write, req_page, req_last} = 5'h10;
    {req_addr, req_wdata, r} = {26'h0, 32'h0, 32'h2a};
    repeat (6) @(negedge core_clk);
    rst = 0;
    chk("mode after reset", 32'h1, 32'(pg_n));
    acc(1, 0, 1, 26'h5);
    acc(0, 0, 1, 26'h5);
    $display("single word test done");
    for (int i = 0; i < 4; i++) acc(1, 1, i == 3, 26'h8 + 26'(i));
    for (int k = 0; k < 4; k++) acc(0, 1, k == 3, 26'h8 + 26'((k * 3) % 4));
    $display("page test done");
    @(negedge core_clk) rst = 1;
    repeat (2) @(negedge core_clk);
    rst = 0;
    chk("mode after second reset", 32'h1, 32'(pg_n));
    $display("reset test done");
    acc(1, 1, 0, 26'hd);
    acc(1, 1, 1, 26'h1);
    acc(0, 0, 1, 26'hd);
    acc(0, 0, 1, 26'h1);
    acc(0, 0, 1, 26'h9);
    $display("page change test done");
    tally_and_finish();
  end
endmodule // apm_ctrl_tb_top
bind apm_ctrl apm_ctrl_checker #(.AW(AW)) u_chk (.core_clk, .rst,
  .req_ready, .rsp_valid, .mem_addr, .bank_one_select_n, .mem_oe_n,
  .mem_we_n, .page_mode_select_n, .mem_dq_oe);
`default_nettype wire
